/* design/swru_pkg.sv */
package swru_pkg;

  // Instruction format.
  localparam logic [1:0] SWRU_OP_FMT3 = 2'h2;
  localparam int SWRU_OP_LSB = 30;
  localparam int SWRU_RD_LSB = 25;
  localparam int SWRU_OP3_LSB = 19;
  localparam int SWRU_IMM_SEL_BIT = 13;
  localparam int SWRU_SIMM_MSB = 12;
  localparam logic [5:0] SWRU_OP3_MULDIV = 6'h30;
  localparam logic [5:0] SWRU_OP3_PSR = 6'h31;
  localparam logic [5:0] SWRU_OP3_WIM = 6'h32;
  localparam logic [5:0] SWRU_OP3_TBR = 6'h33;
  localparam logic [4:0] SWRU_ASR_IMPL_FIRST = 5'h10;

  // Processor state register fields.
  localparam int SWRU_CWP_LSB = 0;
  localparam int SWRU_CWP_W = 5;
  localparam int SWRU_ET_BIT = 5;
  localparam int SWRU_S_BIT = 7;
  localparam int SWRU_PIL_LSB = 8;
  localparam int SWRU_PIL_W = 4;
  localparam logic [4:0] SWRU_WINDOW_COUNT = 5'h08;

  // Writable bits of each target, and the privileged ancillary mask.
  localparam logic [31:0] SWRU_MULDIV_WMASK = 32'hffffffff;
  localparam logic [31:0] SWRU_PSR_WMASK = 32'h00ffffff;
  localparam logic [31:0] SWRU_WIM_WMASK = 32'h000000ff;
  localparam logic [31:0] SWRU_TBR_WMASK = 32'hfffff000;
  localparam logic [15:0] SWRU_ASR_PRIV_MASK = 16'hff00;

  // Reset values.
  localparam logic [31:0] SWRU_PSR_RST = 32'h00000080;
  localparam logic [31:0] SWRU_REG_RST = 32'h00000000;
  localparam logic [1:0] SWRU_DELAY_RST = 2'h3;

  // Wishbone byte offsets.
  localparam logic [7:0] SWRU_OFS_CTRL = 8'h00;
  localparam logic [7:0] SWRU_OFS_STATUS = 8'h04;
  localparam logic [7:0] SWRU_OFS_MULDIV = 8'h08;
  localparam logic [7:0] SWRU_OFS_PSR = 8'h0c;
  localparam logic [7:0] SWRU_OFS_WIM = 8'h10;
  localparam logic [7:0] SWRU_OFS_TBR = 8'h14;
  localparam logic [1:0] SWRU_OFS_ASR_PAGE = 2'h1;

  localparam int SWRU_SLOTS = 5;

  typedef enum logic [2:0] {
    SWRU_TGT_MULDIV,
    SWRU_TGT_PSR,
    SWRU_TGT_WIM,
    SWRU_TGT_TBR,
    SWRU_TGT_ASR
  } swru_tgt_e;

  function automatic logic [31:0] swru_merge(input logic [31:0] old,
                                             input logic [31:0] val,
                                             input logic [31:0] mask);
    swru_merge = (old & ~mask) | (val & mask);
  endfunction

  function automatic logic [31:0] swru_wmask(input int slot);
    case (slot)
      0: swru_wmask = SWRU_MULDIV_WMASK;
      1: swru_wmask = SWRU_PSR_WMASK;
      2: swru_wmask = SWRU_WIM_WMASK;
      3: swru_wmask = SWRU_TBR_WMASK;
      default: swru_wmask = 32'hffffffff;
    endcase
  endfunction

endpackage

/* design/swru_dec_if.sv */
interface swru_dec_if;
  import swru_pkg::*;
  logic hit;
  swru_tgt_e tgt;
  logic [4:0] asr_idx;
  logic [31:0] value;
  logic priv_req;
  logic bad_cwp;
  logic reserved_asr;
  modport dec (output hit, tgt, asr_idx, value, priv_req, bad_cwp,
               reserved_asr);
  modport core (input hit, tgt, asr_idx, value, priv_req, bad_cwp,
                reserved_asr);
endinterface

/* design/swru_decode.sv */
module swru_decode
  import swru_pkg::*;
(
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] src_a_value,
  input wire logic [31:0] src_b_value,
  swru_dec_if.dec dec
);
  import swru_pkg::*;

  wire [1:0] op_field = instr_word[SWRU_OP_LSB +: 2];
  wire [4:0] dest_field = instr_word[SWRU_RD_LSB +: 5];
  wire [5:0] opcode_ext_field = instr_word[SWRU_OP3_LSB +: 6];
  wire imm_sel = instr_word[SWRU_IMM_SEL_BIT];
  wire [31:0] signed_immediate =
    {{19{instr_word[SWRU_SIMM_MSB]}}, instr_word[SWRU_SIMM_MSB:0]};
  wire fmt_ok = instr_valid && (op_field == SWRU_OP_FMT3);
  wire sel_muldiv = fmt_ok && (opcode_ext_field == SWRU_OP3_MULDIV) &&
                    (dest_field == 5'h00);
  wire sel_asr = fmt_ok && (opcode_ext_field == SWRU_OP3_MULDIV) &&
                 (dest_field != 5'h00);
  wire sel_psr = fmt_ok && (opcode_ext_field == SWRU_OP3_PSR);
  wire sel_wim = fmt_ok && (opcode_ext_field == SWRU_OP3_WIM);
  wire sel_tbr = fmt_ok && (opcode_ext_field == SWRU_OP3_TBR);
  wire [3:0] asr_slot = dest_field[3:0];
  wire asr_impl = dest_field >= SWRU_ASR_IMPL_FIRST;

  assign dec.hit = sel_muldiv || sel_asr || sel_psr || sel_wim || sel_tbr;
  assign dec.tgt = sel_psr ? SWRU_TGT_PSR :
                   sel_wim ? SWRU_TGT_WIM :
                   sel_tbr ? SWRU_TGT_TBR :
                   sel_asr ? SWRU_TGT_ASR : SWRU_TGT_MULDIV;
  assign dec.asr_idx = dest_field;
  // implemented ancillaries use the same xor form
  assign dec.value = src_a_value ^ (imm_sel ? signed_immediate : src_b_value);
  assign dec.priv_req = sel_psr || sel_wim || sel_tbr ||
                        (sel_asr && asr_impl && SWRU_ASR_PRIV_MASK[asr_slot]);
  assign dec.reserved_asr = sel_asr && !asr_impl;
  assign dec.bad_cwp = sel_psr &&
    (dec.value[SWRU_CWP_LSB +: SWRU_CWP_W] >= SWRU_WINDOW_COUNT);

endmodule

/* design/swru_top.sv */
// Summary of operation
// - op3 0x30: rd zero muldiv, else ancillary
// - op3 0x31/0x32/0x33 write state, mask, base
// - State writes privileged; ancillary per register
// - Value is source a xor b or immediate
// - Ancillary 1 to 15 reserved, no effect
// - Ancillary 16 to 31 implementation defined
// - Ancillary writes never touch muldiv register
// - Bad window pointer traps, state unchanged
// - Writes complete after zero to three instructions
// - Trap enable and level seen immediately
// - Repeated same write takes effect as intended
// - Reads of changed fields within three undefined
// - Window ops near mask write unpredictable
// - Muldiv readers near muldiv write undefined
// - Old level interrupt may slip through
// - Trap entry may use old or new state
// - Trap may use old or new base
// - Handler reads see the new value
module swru_top
  import swru_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] wb_adr,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  input wire logic wb_we,
  input wire logic [3:0] wb_sel,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  output logic wb_ack,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] src_a_value,
  input wire logic [31:0] src_b_value,
  input wire logic trap_taken,
  output logic [31:0] muldiv_reg,
  output logic [31:0] proc_state,
  output logic [31:0] window_mask,
  output logic [31:0] trap_base,
  output logic trap_enable,
  output logic [3:0] interrupt_level,
  output logic [4:0] write_pending,
  output logic trap_privileged,
  output logic trap_illegal
);
  import swru_pkg::*;

  logic rst_meta_q;
  logic rst_sync_q;
  logic [1:0] delay_q;
  logic [31:0] arch_q [4];
  logic [31:0] asr_mem [16];
  logic [1:0] cnt_q [SWRU_SLOTS];
  logic [1:0] cnt_d [SWRU_SLOTS];
  logic [31:0] val_q [SWRU_SLOTS];
  logic [31:0] val_d [SWRU_SLOTS];
  logic [4:0] asr_idx_q;
  logic [4:0] commit;
  logic [31:0] commit_val [SWRU_SLOTS];
  logic [4:0] commit_asr_idx;
  logic [4:0] pend_q;
  logic et_view_q;
  logic [3:0] pil_view_q;
  logic priv_q;
  logic illegal_q;
  logic ack_q;
  logic [31:0] rdat_q;

  swru_dec_if dec_bus ();

  swru_decode u_decode (
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .src_a_value(src_a_value),
    .src_b_value(src_b_value),
    .dec(dec_bus.dec)
  );

  // Reset is released through two flops so that all state except the ancillary array
  // leaves reset on the same edge.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  wire rst_n = rst_sync_q;

  wire priv_fault = dec_bus.hit && dec_bus.priv_req &&
                    !arch_q[1][SWRU_S_BIT];
  wire cwp_fault = dec_bus.hit && !priv_fault && dec_bus.bad_cwp;
  wire do_write = dec_bus.hit && !priv_fault && !cwp_fault &&
                  !dec_bus.reserved_asr;
  wire write_now = (delay_q == 2'h0) || trap_taken;
  wire psr_issue = do_write && (dec_bus.tgt == SWRU_TGT_PSR);

  always_comb begin
    commit_asr_idx = asr_idx_q;
    for (int i = 0; i < SWRU_SLOTS; i++) begin
      logic new_here;
      logic expire;
      new_here = do_write && (int'(dec_bus.tgt) == i);
      // a trap forces any pending write out
      expire = (cnt_q[i] != 2'h0) &&
               ((instr_valid && (cnt_q[i] == 2'h1)) || trap_taken);
      commit[i] = new_here ? write_now : expire;
      commit_val[i] = new_here ? dec_bus.value : val_q[i];
      val_d[i] = new_here ? dec_bus.value : val_q[i];
      if (new_here) begin
        cnt_d[i] = write_now ? 2'h0 : delay_q;
      end else if (expire) begin
        cnt_d[i] = 2'h0;
      end else if (instr_valid && (cnt_q[i] != 2'h0)) begin
        cnt_d[i] = cnt_q[i] - 2'h1;
      end else begin
        cnt_d[i] = cnt_q[i];
      end
    end
    if (do_write && (dec_bus.tgt == SWRU_TGT_ASR)) begin
      commit_asr_idx = dec_bus.asr_idx;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SWRU_SLOTS; i++) begin
        cnt_q[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < SWRU_SLOTS; i++) begin
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SWRU_SLOTS; i++) begin
        val_q[i] <= SWRU_REG_RST;
      end
    end else begin
      for (int i = 0; i < SWRU_SLOTS; i++) begin
        val_q[i] <= val_d[i];
      end
    end
  end

  // pending flags mark the hazard window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 5'h00;
    end else begin
      for (int i = 0; i < SWRU_SLOTS; i++) begin
        pend_q[i] <= (cnt_d[i] != 2'h0);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      asr_idx_q <= 5'h00;
    end else begin
      asr_idx_q <= commit_asr_idx;
    end
  end

  // committed values are what handlers read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arch_q[0] <= SWRU_REG_RST;
      arch_q[1] <= SWRU_PSR_RST;
      arch_q[2] <= SWRU_REG_RST;
      arch_q[3] <= SWRU_REG_RST;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (commit[i]) begin
          arch_q[i] <= swru_merge(arch_q[i], commit_val[i], swru_wmask(i));
        end
      end
    end
  end

  // The ancillary array holds no reset; software must write before reading.
  always_ff @(posedge clk) begin
    if (commit[4]) begin
      asr_mem[commit_asr_idx[3:0]] <= commit_val[4];
    end
  end

  // The view only tracks the register once no state write is waiting.
  wire psr_settled = (cnt_q[1] == 2'h0);

  // interrupt view follows the issued write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      et_view_q <= SWRU_PSR_RST[SWRU_ET_BIT];
      pil_view_q <= SWRU_PSR_RST[SWRU_PIL_LSB +: SWRU_PIL_W];
    end else if (psr_issue) begin
      et_view_q <= dec_bus.value[SWRU_ET_BIT];
      pil_view_q <= dec_bus.value[SWRU_PIL_LSB +: SWRU_PIL_W];
    end else if (psr_settled) begin
      et_view_q <= arch_q[1][SWRU_ET_BIT];
      pil_view_q <= arch_q[1][SWRU_PIL_LSB +: SWRU_PIL_W];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      priv_q <= 1'b0;
    end else begin
      priv_q <= priv_fault;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= cwp_fault;
    end
  end

  // Wishbone slave: ack one cycle after the strobe, read data latched on the edge that raises ack,
  // writes act on the next edge while ack is high, unmapped offsets read zero.
  wire wb_req = wb_cyc && wb_stb;
  wire wb_take = wb_req && !ack_q;
  wire asr_page = wb_adr[7:6] == SWRU_OFS_ASR_PAGE;
  wire hit_ctrl = wb_adr == SWRU_OFS_CTRL;
  wire hit_status = wb_adr == SWRU_OFS_STATUS;
  wire hit_muldiv = wb_adr == SWRU_OFS_MULDIV;
  wire hit_psr = wb_adr == SWRU_OFS_PSR;
  wire hit_wim = wb_adr == SWRU_OFS_WIM;
  wire hit_tbr = wb_adr == SWRU_OFS_TBR;
  wire ctrl_wr = wb_req && ack_q && wb_we && wb_sel[0] && hit_ctrl;
  wire [31:0] status_word = {27'h0, pend_q};
  wire [31:0] rd_mux =
    asr_page ? asr_mem[wb_adr[5:2]] :
    hit_ctrl ? {30'h0, delay_q} :
    hit_status ? status_word :
    hit_muldiv ? arch_q[0] :
    hit_psr ? arch_q[1] :
    hit_wim ? arch_q[2] :
    hit_tbr ? arch_q[3] : 32'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_take;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdat_q <= 32'h0;
    end else if (wb_take) begin
      rdat_q <= rd_mux;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_q <= SWRU_DELAY_RST;
    end else if (ctrl_wr) begin
      delay_q <= wb_dat_w[1:0];
    end
  end

  assign wb_ack = ack_q;
  assign wb_dat_r = rdat_q;
  assign muldiv_reg = arch_q[0];
  assign proc_state = arch_q[1];
  assign window_mask = arch_q[2];
  assign trap_base = arch_q[3];
  assign trap_enable = et_view_q;
  assign interrupt_level = pil_view_q;
  // mask pending visible to window logic
  // muldiv pending visible to muldiv users
  assign write_pending = pend_q;
  assign trap_privileged = priv_q;
  assign trap_illegal = illegal_q;

endmodule

/* dv/swru_chk.sv */
module swru_chk
  import swru_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_ack,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] src_a_value,
  input wire logic [31:0] src_b_value,
  input wire logic trap_taken,
  input wire logic [31:0] muldiv_reg,
  input wire logic [31:0] proc_state,
  input wire logic trap_enable,
  input wire logic [3:0] interrupt_level,
  input wire logic [4:0] write_pending,
  input wire logic trap_privileged,
  input wire logic trap_illegal
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic [31:0] imm = {{19{instr_word[12]}}, instr_word[12:0]};
  wire logic [31:0] val = src_a_value ^ (instr_word[13] ? imm : src_b_value);
  wire logic [5:0] op3 = instr_word[24:19];
  wire logic fmt = instr_valid && instr_word[31:30] == SWRU_OP_FMT3;
  wire logic psr_wr = fmt && op3 == SWRU_OP3_PSR;
  wire logic priv_wr = psr_wr || (fmt && op3 == SWRU_OP3_WIM) ||
                       (fmt && op3 == SWRU_OP3_TBR);
  wire logic y_wr = fmt && op3 == SWRU_OP3_MULDIV &&
                    instr_word[29:25] == 5'h0;
  wire logic sup = proc_state[SWRU_S_BIT];
  wire logic cwp_bad = val[4:0] >= SWRU_WINDOW_COUNT;
  // Counts instructions seen while a state write waits; a new one restarts.
  logic [1:0] cnt_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt_q <= 2'h0;
    else if (!write_pending[1] || psr_wr) cnt_q <= 2'h0;
    else if (instr_valid) cnt_q <= cnt_q + 2'h1;
  end
  ack_answer_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("bus request not answered next cycle");
  ack_pulse_a: assert property (wb_ack |=> !wb_ack)
    else $error("ack held longer than one cycle");
  priv_trap_a: assert property (priv_wr && !sup |=> trap_privileged)
    else $error("user state write did not trap");
  priv_only_a: assert property (trap_privileged |-> !$past(sup))
    else $error("privilege trap in supervisor mode");
  cwp_trap_a: assert property (psr_wr && sup && cwp_bad |=>
    trap_illegal)
    else $error("bad window pointer did not trap");
  trap_order_a: assert property (trap_illegal |-> !trap_privileged)
    else $error("both fault pulses at once");
  irq_view_a: assert property (psr_wr && sup && !cwp_bad |=>
    trap_enable == $past(val[5]) && interrupt_level == $past(val[11:8]))
    else $error("interrupt view not updated at once");
  muldiv_val_a: assert property (y_wr && trap_taken |=>
    muldiv_reg == $past(val))
    else $error("muldiv value wrong");
  trap_flush_a: assert property (trap_taken |=>
    write_pending == 5'h0)
    else $error("trap left writes pending");
  delay_max_a: assert property (write_pending[1] |-> cnt_q != 2'h3)
    else $error("state write delayed too long");
  cover property (trap_illegal);
  cover property (trap_privileged);
  cover property (write_pending[1] && instr_valid);
endmodule

bind swru_top swru_chk i_swru_chk (.*);

/* dv/tb_state_register_write_unit.sv */
module tb_state_register_write_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import swru_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic wb_we = 1'b0;
  logic [3:0] wb_sel = 4'h0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_ack;
  logic instr_valid = 1'b0;
  logic [31:0] instr_word = 32'h0;
  logic [31:0] src_a_value = 32'h0;
  logic [31:0] src_b_value = 32'h0;
  logic trap_taken = 1'b0;
  logic [31:0] muldiv_reg, proc_state, window_mask, trap_base, r;
  logic trap_enable, trap_privileged, trap_illegal;
  logic [3:0] interrupt_level;
  logic [4:0] write_pending;
  int err_count = 0;
  int n_tests = 0;
  swru_top i_swru_top (.*);
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // The wait is bounded so a dead slave ends the run instead of hanging.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= d;
    wb_sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    r = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1) begin
      err_count++;
      summarize();
    end
  endtask
  task automatic ex(input logic [31:0] w, input logic [31:0] a,
                    input logic [31:0] b, input logic t);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    src_a_value <= a;
    src_b_value <= b;
    trap_taken <= t;
    @(posedge clk);
    instr_valid <= 1'b0;
    trap_taken <= 1'b0;
    @(negedge clk);
  endtask
  function automatic logic [31:0] ins(input logic [4:0] d,
      input logic [5:0] o, input logic i, input logic [12:0] m);
    return {2'h2, d, o, 5'h01, i, m};
  endfunction
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(proc_state, SWRU_PSR_RST);
    chk(muldiv_reg, SWRU_REG_RST);
    wb(1'b0, SWRU_OFS_CTRL, 32'h0);
    chk(r, {30'h0, SWRU_DELAY_RST});
    wb(1'b0, 8'hfc, 32'h0);
    chk(r, 32'h0);
    $display("test 1 done");
    wb(1'b1, SWRU_OFS_CTRL, 32'h0);
    ex(ins(5'h0, SWRU_OP3_PSR, 1'b0, 13'h0), 32'h12345a83, 32'h1, 1'b0);
    chk(proc_state, 32'h00345a82);
    chk(interrupt_level, 4'ha);
    ex(ins(5'h0, SWRU_OP3_WIM, 1'b1, 13'h1ff5), 32'h0, 32'h0, 1'b0);
    chk(window_mask, 32'hf5);
    ex(ins(5'h0, SWRU_OP3_TBR, 1'b1, 13'h0), 32'hffffffff, 32'h0, 1'b0);
    chk(trap_base, 32'hfffff000);
    ex(ins(5'h0, SWRU_OP3_MULDIV, 1'b0, 13'h0), 32'hdeadbeef, 32'h0f0f0f0f,
       1'b0);
    chk(muldiv_reg, 32'hd1a2b1e0);
    ex(ins(5'h10, SWRU_OP3_MULDIV, 1'b1, 13'h0a), 32'h55, 32'h0, 1'b0);
    ex(ins(5'h05, SWRU_OP3_MULDIV, 1'b0, 13'h0), 32'h1, 32'h0, 1'b0);
    chk(muldiv_reg, 32'hd1a2b1e0);
    chk(trap_illegal, 1'b0);
    wb(1'b0, 8'h40, 32'h0);
    chk(r, 32'h5f);
    wb(1'b0, SWRU_OFS_PSR, 32'h0);
    chk(r, 32'h00345a82);
    $display("test 2 done");
    ex(ins(5'h0, SWRU_OP3_PSR, 1'b0, 13'h0), 32'h00345a88, 32'h0, 1'b0);
    chk(trap_illegal, 1'b1);
    chk(proc_state, 32'h00345a82);
    $display("test 3 done");
    wb(1'b1, SWRU_OFS_CTRL, 32'h3);
    ex(ins(5'h0, SWRU_OP3_PSR, 1'b0, 13'h0), 32'h1a3, 32'h0, 1'b0);
    chk({trap_enable, interrupt_level}, 5'h11);
    for (int k = 0; k < 3; k++) begin
      chk(proc_state, 32'h00345a82);
      chk(write_pending, 5'h02);
      ex(32'h0, 32'h0, 32'h0, 1'b0);
    end
    chk(proc_state, 32'h1a3);
    repeat (2) ex(ins(5'h0, SWRU_OP3_WIM, 1'b1, 13'h3c), 0, 0, 1'b0);
    chk(write_pending, 5'h04);
    ex(ins(5'h0, SWRU_OP3_MULDIV, 1'b1, 13'h00f), 32'h0, 32'h0, 1'b1);
    chk(window_mask, 32'h3c);
    chk(muldiv_reg, 32'hf);
    chk(write_pending, 5'h0);
    $display("test 4 done");
    wb(1'b1, SWRU_OFS_CTRL, 32'h0);
    // state writes carry whole values, never read-modify-write.
    ex(ins(5'h0, SWRU_OP3_PSR, 1'b0, 13'h0), 32'h283, 32'h0, 1'b0);
    chk({trap_enable, interrupt_level}, 5'h02);
    ex(ins(5'h0, SWRU_OP3_PSR, 1'b0, 13'h0), 32'h2a3, 32'h0, 1'b0);
    chk({trap_enable, interrupt_level}, 5'h12);
    ex(ins(5'h0, SWRU_OP3_PSR, 1'b1, 13'h003), 32'h0, 32'h0, 1'b0);
    chk(proc_state, 32'h3);
    ex(ins(5'h0, SWRU_OP3_WIM, 1'b1, 13'h1), 32'h0, 32'h0, 1'b0);
    chk(trap_privileged, 1'b1);
    chk(window_mask, 32'h3c);
    ex(ins(5'h18, SWRU_OP3_MULDIV, 1'b1, 13'h7), 32'h0, 32'h0, 1'b0);
    chk(trap_privileged, 1'b1);
    ex(ins(5'h11, SWRU_OP3_MULDIV, 1'b0, 13'h0), 32'h77, 32'h700, 1'b0);
    chk(trap_privileged, 1'b0);
    wb(1'b0, 8'h44, 32'h0);
    chk(r, 32'h777);
    $display("test 5 done");
    summarize();
  end
endmodule
